// >>> core/acb_alu.sv
// Combinational accumulator math for the ten operation types
`timescale 1ns/100ps
module acb_alu import acb_pkg::*; (
    input wire logic [31:0] acc_i,
    input wire logic [31:0] operand_i,
    input wire logic [7:0] op_i,
    output logic [31:0] result_o,
    output logic ok_o
);
    // Division by zero and unknown types leave the accumulator alone
    always_comb begin
        result_o = acc_i;
        ok_o = 1'b1;
        case (op_i)
            OP_ADD: result_o = acc_i + operand_i;
            OP_SUB: result_o = acc_i - operand_i;
            OP_MUL: result_o = acc_i * operand_i;
            OP_DIV: begin
                if (operand_i == 32'h00000000) ok_o = 1'b0;
                else result_o = 32'($signed(acc_i) / $signed(operand_i));
            end
            OP_MOD: begin
                if (operand_i == 32'h00000000) ok_o = 1'b0;
                else result_o = 32'($signed(acc_i) % $signed(operand_i));
            end
            OP_AND: result_o = acc_i & operand_i;
            OP_OR: result_o = acc_i | operand_i;
            OP_XOR: result_o = acc_i ^ operand_i;
            OP_NOT: result_o = ~acc_i;
            OP_LOAD: result_o = operand_i;
            default: ok_o = 1'b0;
        endcase
    end
endmodule : acb_alu

// >>> core/acb_core.sv
// Accumulator math, compare and conditional jump executer with frame reply
`timescale 1ns/100ps
module acb_core import acb_pkg::*; #(
    parameter logic [7:0] MODULE_ADDR = 8'h01,
    parameter logic [7:0] HOST_ADDR = 8'h02,
    parameter logic [7:0] STATUS_BAD_CMD = 8'h02,
    parameter logic [7:0] STATUS_BAD_TYPE = 8'h03
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    input wire logic standalone_i,
    input wire logic prog_valid_i,
    input wire logic [7:0] prog_instr_i,
    input wire logic [7:0] prog_type_i,
    input wire logic [7:0] prog_bank_i,
    input wire logic [31:0] prog_value_i,
    input wire logic wait_timeout_i,
    input wire logic clear_err_i,
    input wire logic ext_alarm_i,
    input wire logic deviation_err_i,
    input wire logic position_err_i,
    output logic prog_ack_o,
    output logic [31:0] pc_o,
    output logic [31:0] acc_o,
    output logic [3:0] gpio_out_o,
    output logic [7:0] tx_byte_o,
    output logic tx_valid_o,
    output logic frame_err_o,
    output logic timeout_flag_o
);
    acb_cmd_if cmd_if ();

    logic [31:0] acc_r, acc_nxt;
    logic [31:0] pc_r, pc_nxt;
    logic [3:0] out_r, out_nxt;
    logic zero_r, zero_nxt;
    logic eq_r, eq_nxt;
    logic gt_r, gt_nxt;
    logic lt_r, lt_nxt;
    logic timeout_r, timeout_nxt;
    logic ack_r, ack_nxt;
    logic [7:0] rep_r [0:7];
    logic [7:0] rep_nxt [0:7];
    logic [3:0] idx_r, idx_nxt;
    logic busy_r, busy_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic txv_r, txv_nxt;
    logic host_go, prog_go, exec_go;
    logic [7:0] ex_instr, ex_type, ex_bank;
    logic [31:0] ex_value;
    logic [31:0] alu_res;
    logic alu_ok;
    logic cond_true;
    logic [7:0] status;
    logic [31:0] rep_value;
    logic [31:0] gio_value;
    logic [63:0] rep_body;

    acb_frame_rx #(.MODULE_ADDR(MODULE_ADDR)) u_rx (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .rx_byte_i(rx_byte_i),
        .rx_valid_i(rx_valid_i),
        .frame_err_o(frame_err_o),
        .cmd(cmd_if.rx)
    );

    acb_alu u_alu (
        .acc_i(acc_r),
        .operand_i(ex_value),
        .op_i(ex_type),
        .result_o(alu_res),
        .ok_o(alu_ok)
    );

    // Host frames win over program steps; a frame arriving while a reply is out is dropped
    assign host_go = cmd_if.valid && !busy_r;
    assign prog_go = !cmd_if.valid && standalone_i && prog_valid_i && !ack_r;
    assign exec_go = host_go || prog_go;
    assign ex_instr = host_go ? cmd_if.instr : prog_instr_i;
    assign ex_type = host_go ? cmd_if.typ : prog_type_i;
    assign ex_bank = host_go ? cmd_if.bank : prog_bank_i;
    assign ex_value = host_go ? cmd_if.value : prog_value_i;

    // Condition select over the latest compare and the error flags
    always_comb begin
        case (ex_type)
            CND_ZE: cond_true = zero_r;
            CND_NZ: cond_true = !zero_r;
            CND_EQ: cond_true = eq_r;
            CND_NE: cond_true = !eq_r;
            CND_GT: cond_true = gt_r;
            CND_GE: cond_true = gt_r || eq_r;
            CND_LT: cond_true = lt_r;
            CND_LE: cond_true = lt_r || eq_r;
            CND_TIMEOUT: cond_true = timeout_r;
            CND_ALARM: cond_true = ext_alarm_i;
            CND_DEVIATION: cond_true = deviation_err_i;
            CND_POSITION: cond_true = position_err_i;
            default: cond_true = 1'b0;
        endcase
    end

    // Output line read-back; ports beyond the four lines read zero
    assign gio_value = (ex_type < 8'(NUM_OUT)) ? {31'h00000000, out_r[ex_type[1:0]]} : 32'h00000000;

    // Execution of one command; the motor/bank byte only matters for output access
    always_comb begin
        acc_nxt = acc_r;
        pc_nxt = pc_r;
        out_nxt = out_r;
        zero_nxt = zero_r;
        eq_nxt = eq_r;
        gt_nxt = gt_r;
        lt_nxt = lt_r;
        status = STATUS_OK;
        rep_value = 32'h00000000;
        if (exec_go) begin
            if (prog_go) pc_nxt = pc_r + 32'h00000001;
            case (ex_instr)
                INS_MATH: begin
                    if (alu_ok) acc_nxt = alu_res;
                    else status = STATUS_BAD_TYPE;
                    rep_value = ex_value;
                end
                INS_COMPARE: begin
                    zero_nxt = (acc_r - ex_value) == 32'h00000000;
                    eq_nxt = acc_r == ex_value;
                    gt_nxt = $signed(acc_r) > $signed(ex_value);
                    lt_nxt = $signed(acc_r) < $signed(ex_value);
                end
                INS_COND_JUMP: begin
                    if (cond_true) pc_nxt = ex_value;
                end
                INS_GET_INPUT: begin
                    if (ex_bank != BANK_OUT_STATE) status = STATUS_BAD_TYPE;
                    rep_value = gio_value;
                    if (prog_go) acc_nxt = gio_value;
                end
                INS_SET_OUTPUT: begin
                    if (ex_bank == BANK_OUT_STATE && ex_type < 8'(NUM_OUT)) out_nxt[ex_type[1:0]] = ex_value[0];
                    else status = STATUS_BAD_TYPE;
                end
                default: status = STATUS_BAD_CMD;
            endcase
        end
    end

    // Timeout flag: a timeout in the clearing cycle still sets it
    always_comb begin
        timeout_nxt = timeout_r;
        if (clear_err_i) timeout_nxt = 1'b0;
        if (wait_timeout_i) timeout_nxt = 1'b1;
        ack_nxt = prog_go;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_r <= 32'h00000000;
            pc_r <= 32'h00000000;
            out_r <= 4'h0;
            zero_r <= 1'b0;
            eq_r <= 1'b0;
            gt_r <= 1'b0;
            lt_r <= 1'b0;
            timeout_r <= 1'b0;
            ack_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            pc_r <= pc_nxt;
            out_r <= out_nxt;
            zero_r <= zero_nxt;
            eq_r <= eq_nxt;
            gt_r <= gt_nxt;
            lt_r <= lt_nxt;
            timeout_r <= timeout_nxt;
            ack_r <= ack_nxt;
        end
    end

    // Reply body in wire order; checksum is summed as the last byte leaves
    always_comb begin
        for (int i = 0; i < FRAME_BODY; i++) begin
            rep_body[63 - 8 * i -: 8] = rep_r[i];
        end
    end

    // Reply builder and byte serialiser, one byte per clock with no back-pressure
    always_comb begin
        rep_nxt = rep_r;
        idx_nxt = idx_r;
        busy_nxt = busy_r;
        tx_nxt = 8'h00;
        txv_nxt = 1'b0;
        if (host_go) begin
            rep_nxt[0] = HOST_ADDR;
            rep_nxt[1] = MODULE_ADDR;
            rep_nxt[2] = status;
            rep_nxt[3] = ex_instr;
            rep_nxt[4] = rep_value[31:24];
            rep_nxt[5] = rep_value[23:16];
            rep_nxt[6] = rep_value[15:8];
            rep_nxt[7] = rep_value[7:0];
            idx_nxt = 4'h0;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            txv_nxt = 1'b1;
            if (idx_r < 4'(FRAME_BODY)) begin
                tx_nxt = rep_r[idx_r[2:0]];
                idx_nxt = idx_r + 4'h1;
            end else begin
                tx_nxt = acb_csum(rep_body);
                busy_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < FRAME_BODY; i++) rep_r[i] <= 8'h00;
            idx_r <= 4'h0;
            busy_r <= 1'b0;
            tx_r <= 8'h00;
            txv_r <= 1'b0;
        end else begin
            rep_r <= rep_nxt;
            idx_r <= idx_nxt;
            busy_r <= busy_nxt;
            tx_r <= tx_nxt;
            txv_r <= txv_nxt;
        end
    end

    assign prog_ack_o = ack_r;
    assign pc_o = pc_r;
    assign acc_o = acc_r;
    assign gpio_out_o = out_r;
    assign tx_byte_o = tx_r;
    assign tx_valid_o = txv_r;
    assign timeout_flag_o = timeout_r;

    // Checks on the executer
    property p_math_add;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        exec_go && ex_instr == INS_MATH && ex_type == OP_ADD |=> acc_r == $past(acc_r) + $past(ex_value);
    endproperty
    a_math_add: assert property (p_math_add) else $error("add result wrong");

    property p_math_not;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        exec_go && ex_instr == INS_MATH && ex_type == OP_NOT |=> acc_r == ~$past(acc_r);
    endproperty
    a_math_not: assert property (p_math_not) else $error("invert result wrong");

    property p_math_load;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        exec_go && ex_instr == INS_MATH && ex_type == OP_LOAD |=> acc_r == $past(ex_value);
    endproperty
    a_math_load: assert property (p_math_load) else $error("load result wrong");

    property p_compare_flags;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        exec_go && ex_instr == INS_COMPARE |=> eq_r == ($past(acc_r) == $past(ex_value)) && !(gt_r && lt_r);
    endproperty
    a_compare_flags: assert property (p_compare_flags) else $error("compare flags wrong");

    property p_jump_path;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        prog_go && ex_instr == INS_COND_JUMP |=>
            pc_r == ($past(cond_true) ? $past(ex_value) : $past(pc_r) + 32'h00000001);
    endproperty
    a_jump_path: assert property (p_jump_path) else $error("jump target wrong");

    property p_direct_input_keeps_acc;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        host_go && ex_instr == INS_GET_INPUT |=> $stable(acc_r) && rep_r[7] == {7'h00, $past(gio_value[0])};
    endproperty
    a_direct_input_keeps_acc: assert property (p_direct_input_keeps_acc) else $error("direct read changed acc");

    property p_timeout_sticky;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        timeout_r && !clear_err_i |=> timeout_r;
    endproperty
    a_timeout_sticky: assert property (p_timeout_sticky) else $error("timeout flag dropped");

    // A timeout beats a clear that lands in the same cycle
    property p_timeout_set_wins;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wait_timeout_i |=> timeout_r;
    endproperty
    a_timeout_set_wins: assert property (p_timeout_set_wins) else $error("timeout flag not set");

    sequence s_math_cmd;
        host_go && ex_instr == INS_MATH && alu_ok;
    endsequence
    sequence s_reply_head;
        ##2 tx_valid_o && tx_byte_o == HOST_ADDR ##1 tx_valid_o && tx_byte_o == MODULE_ADDR
            ##1 tx_valid_o && tx_byte_o == STATUS_OK ##1 tx_valid_o && tx_byte_o == INS_MATH;
    endsequence
    property p_math_reply;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        s_math_cmd |-> s_reply_head;
    endproperty
    a_math_reply: assert property (p_math_reply) else $error("math reply header wrong");

    property p_reply_length;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        host_go |=> ##1 tx_valid_o [*8] ##1 tx_valid_o ##1 !tx_valid_o;
    endproperty
    a_reply_length: assert property (p_reply_length) else $error("reply not nine bytes");
endmodule : acb_core

// >>> core/acb_frame_rx.sv
// Nine-byte command frame assembler with address match and checksum test
`timescale 1ns/100ps
module acb_frame_rx import acb_pkg::*; #(
    parameter logic [7:0] MODULE_ADDR = 8'h01
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    output logic frame_err_o,
    acb_cmd_if.rx cmd
);
    logic [7:0] buf_r [0:7];
    logic [7:0] buf_nxt [0:7];
    logic [3:0] cnt_r, cnt_nxt;
    logic valid_r, valid_nxt;
    logic err_r, err_nxt;
    logic [63:0] body;

    // Fields stay stable during the valid pulse; only byte 0 can be overwritten then
    always_comb begin
        for (int i = 0; i < FRAME_BODY; i++) begin
            body[63 - 8 * i -: 8] = buf_r[i];
        end
    end
    assign cmd.valid = valid_r;
    assign cmd.instr = buf_r[1];
    assign cmd.typ = buf_r[2];
    assign cmd.bank = buf_r[3];
    assign cmd.value = {buf_r[4], buf_r[5], buf_r[6], buf_r[7]};
    assign frame_err_o = err_r;

    // Byte collection; ninth byte is the checksum
    always_comb begin
        buf_nxt = buf_r;
        cnt_nxt = cnt_r;
        valid_nxt = 1'b0;
        err_nxt = 1'b0;
        if (rx_valid_i) begin
            if (cnt_r < 4'(FRAME_BODY)) begin
                buf_nxt[cnt_r[2:0]] = rx_byte_i;
                cnt_nxt = cnt_r + 4'h1;
            end else begin
                cnt_nxt = 4'h0;
                if (acb_csum(body) != rx_byte_i) err_nxt = 1'b1;
                else if (buf_r[0] == MODULE_ADDR) valid_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < FRAME_BODY; i++) buf_r[i] <= 8'h00;
            cnt_r <= 4'h0;
            valid_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            buf_r <= buf_nxt;
            cnt_r <= cnt_nxt;
            valid_r <= valid_nxt;
            err_r <= err_nxt;
        end
    end

    property p_bad_sum_rejected;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        rx_valid_i && cnt_r == 4'h8 && acb_csum(body) != rx_byte_i |=> err_r && !valid_r;
    endproperty
    a_bad_sum_rejected: assert property (p_bad_sum_rejected) else $error("bad checksum accepted");
endmodule : acb_frame_rx

// >>> include/acb_cmd_if.sv
// Interface carrying one decoded command from the frame receiver to the executer
`timescale 1ns/100ps
interface acb_cmd_if;
    logic valid;
    logic [7:0] instr;
    logic [7:0] typ;
    logic [7:0] bank;
    logic [31:0] value;
    modport rx (output valid, output instr, output typ, output bank, output value);
    modport core (input valid, input instr, input typ, input bank, input value);
endinterface : acb_cmd_if

// >>> include/acb_pkg.sv
// Package of command codes, type codes, frame layout and status values for the accumulator unit
package acb_pkg;
    // Frame layout
    localparam int FRAME_LEN = 9;
    localparam int FRAME_BODY = 8;
    localparam int VALUE_W = 32;
    localparam int NUM_OUT = 4;

    // Instruction codes
    localparam logic [7:0] INS_SET_OUTPUT = 8'h0E;
    localparam logic [7:0] INS_GET_INPUT = 8'h0F;
    localparam logic [7:0] INS_MATH = 8'h13;
    localparam logic [7:0] INS_COMPARE = 8'h14;
    localparam logic [7:0] INS_COND_JUMP = 8'h15;

    // Accumulator math operations
    localparam logic [7:0] OP_ADD = 8'h00;
    localparam logic [7:0] OP_SUB = 8'h01;
    localparam logic [7:0] OP_MUL = 8'h02;
    localparam logic [7:0] OP_DIV = 8'h03;
    localparam logic [7:0] OP_MOD = 8'h04;
    localparam logic [7:0] OP_AND = 8'h05;
    localparam logic [7:0] OP_OR = 8'h06;
    localparam logic [7:0] OP_XOR = 8'h07;
    localparam logic [7:0] OP_NOT = 8'h08;
    localparam logic [7:0] OP_LOAD = 8'h09;

    // Jump conditions
    localparam logic [7:0] CND_ZE = 8'h00;
    localparam logic [7:0] CND_NZ = 8'h01;
    localparam logic [7:0] CND_EQ = 8'h02;
    localparam logic [7:0] CND_NE = 8'h03;
    localparam logic [7:0] CND_GT = 8'h04;
    localparam logic [7:0] CND_GE = 8'h05;
    localparam logic [7:0] CND_LT = 8'h06;
    localparam logic [7:0] CND_LE = 8'h07;
    localparam logic [7:0] CND_TIMEOUT = 8'h08;
    localparam logic [7:0] CND_ALARM = 8'h09;
    localparam logic [7:0] CND_DEVIATION = 8'h0A;
    localparam logic [7:0] CND_POSITION = 8'h0B;

    // Banks and status
    localparam logic [7:0] BANK_OUT_STATE = 8'h02;
    localparam logic [7:0] STATUS_OK = 8'h64;

    // Modulo-256 sum of the eight bytes ahead of the checksum, byte 0 in the top lane
    function automatic logic [7:0] acb_csum(input logic [63:0] body);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < FRAME_BODY; i++) begin
            s = s + body[63 - 8 * i -: 8];
        end
        return s;
    endfunction : acb_csum
endpackage : acb_pkg

// >>> sim/acb_host_model.sv
// Host partner that sends command frames and gathers the reply bytes
`timescale 1ns/100ps
module acb_host_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_valid_i,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o
);
    logic [7:0] reply_q[$];

    initial begin
        rx_byte_o = 8'h00;
        rx_valid_o = 1'b0;
    end

    // Gather every reply byte in arrival order
    always @(posedge clk_sys_i) begin
        if (tx_valid_i === 1'b1) begin
            reply_q.push_back(tx_byte_i);
        end
    end

    // Idle cycles between bytes model a slow host; the line shows junk while idle
    task automatic send_frame(input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] bank,
                              input logic [31:0] val, input int get_axis_param_cmd, input logic bad_sum);
        logic [7:0] b[9];
        b = '{8'h01, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        for (int i = 0; i < 8; i++) begin
            b[8] = b[8] + b[i];
        end
        b[8] = b[8] ^ {7'h00, bad_sum};
        reply_q.delete();
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_sys_i);
            #1;
            rx_byte_o = b[i];
            rx_valid_o = 1'b1;
            if (get_axis_param_cmd > 0) begin
                @(posedge clk_sys_i);
                #1;
                rx_valid_o = 1'b0;
                rx_byte_o = ~rx_byte_o;
                repeat (get_axis_param_cmd - 1) @(posedge clk_sys_i);
            end
        end
        @(posedge clk_sys_i);
        #1;
        rx_valid_o = 1'b0;
        rx_byte_o = ~rx_byte_o;
    endtask : send_frame
endmodule : acb_host_model

// >>> sim/accumulator_accumulator_math_cmd_compare_branch_tb_top.sv
// Self-checking bench for the accumulator math, compare and jump unit
`timescale 1ns/100ps
module accumulator_accumulator_math_cmd_compare_branch_tb_top import acb_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] rx_byte, prog_instr, prog_type, prog_bank, tx_byte;
    logic rx_valid, prog_valid, prog_ack, tx_valid, frame_err, timeout_flag;
    logic standalone = 1'b0;
    logic wait_timeout = 1'b0;
    logic clear_err = 1'b0;
    logic ext_alarm = 1'b0;
    logic deviation_err = 1'b0;
    logic position_err = 1'b0;
    logic [31:0] prog_value, pc, acc, exp_acc, exp_pc;
    logic [3:0] gpio_out;
    logic seen;
    int mismatches = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] opv[10] = '{32'h64, 32'hC8, 32'hFFFFEC78, 32'hFFFFFFF9, 32'h5, 32'hFFFF00FF,
                             32'h0F000000, 32'h00FF00FF, 32'h12345678, 32'h80000000};
    logic [31:0] acc_tab[3] = '{32'h5, 32'hFFFFFFFF, 32'h7};
    logic [31:0] cmp_tab[3] = '{32'h5, 32'h1, 32'h3};

    acb_core dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
        .standalone_i(standalone), .prog_valid_i(prog_valid), .prog_instr_i(prog_instr),
        .prog_type_i(prog_type), .prog_bank_i(prog_bank), .prog_value_i(prog_value),
        .wait_timeout_i(wait_timeout), .clear_err_i(clear_err), .ext_alarm_i(ext_alarm),
        .deviation_err_i(deviation_err), .position_err_i(position_err), .prog_ack_o(prog_ack),
        .pc_o(pc), .acc_o(acc), .gpio_out_o(gpio_out), .tx_byte_o(tx_byte), .tx_valid_o(tx_valid),
        .frame_err_o(frame_err), .timeout_flag_o(timeout_flag));

    acb_host_model host_u (.clk_sys_i(clk_sys_i), .tx_byte_i(tx_byte), .tx_valid_i(tx_valid),
        .rx_byte_o(rx_byte), .rx_valid_o(rx_valid));

    always #12.5 clk_sys_i = ~clk_sys_i;

    // Watchdog well above the several hundred cycles the sequence needs
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    task automatic end_of_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // Signed reference for the ten math types
    function automatic logic [31:0] accumulator_math_cmd_ref(input logic [31:0] a, input logic [7:0] op, input logic [31:0] v);
        case (op)
            OP_ADD: accumulator_math_cmd_ref = a + v;
            OP_SUB: accumulator_math_cmd_ref = a - v;
            OP_MUL: accumulator_math_cmd_ref = a * v;
            OP_DIV: accumulator_math_cmd_ref = $signed(a) / $signed(v);
            OP_MOD: accumulator_math_cmd_ref = $signed(a) % $signed(v);
            OP_AND: accumulator_math_cmd_ref = a & v;
            OP_OR: accumulator_math_cmd_ref = a | v;
            OP_XOR: accumulator_math_cmd_ref = a ^ v;
            OP_NOT: accumulator_math_cmd_ref = ~a;
            default: accumulator_math_cmd_ref = v;
        endcase
    endfunction : accumulator_math_cmd_ref

    function automatic logic cond_ref(input logic [31:0] a, input logic [31:0] v, input int t);
        case (t)
            0, 2: cond_ref = (a == v);
            1, 3: cond_ref = (a != v);
            4: cond_ref = ($signed(a) > $signed(v));
            5: cond_ref = ($signed(a) >= $signed(v));
            6: cond_ref = ($signed(a) < $signed(v));
            default: cond_ref = ($signed(a) <= $signed(v));
        endcase
    endfunction : cond_ref

    // Direct command and full comparison of the nine reply bytes
    task automatic host_cmd(input logic [7:0] ins, typ, bank, input logic [31:0] val, input logic [7:0] st,
                            input logic [31:0] rv, input int get_axis_param_cmd);
        logic [7:0] e[9];
        e = '{8'h02, 8'h01, st, ins, rv[31:24], rv[23:16], rv[15:8], rv[7:0], 8'h00};
        for (int i = 0; i < 8; i++) e[8] = e[8] + e[i];
        host_u.send_frame(ins, typ, bank, val, get_axis_param_cmd, 1'b0);
        repeat (14) @(posedge clk_sys_i);
        #1;
        check(host_u.reply_q.size(), 32'd9, "reply length");
        if (host_u.reply_q.size() == 9) begin
            for (int i = 0; i < 9; i++) check({24'h0, host_u.reply_q[i]}, {24'h0, e[i]}, "reply byte");
        end
    endtask : host_cmd

    // Program step held until acknowledged, then released at once
    task automatic prog_step(input logic [7:0] ins, typ, input logic [31:0] val);
        int n;
        @(posedge clk_sys_i);
        #1;
        // Bank 2 suits the output read-back and is ignored by the other steps
        {prog_instr, prog_type, prog_bank, prog_value} = {ins, typ, BANK_OUT_STATE, val};
        prog_valid = 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys_i);
            #1;
            if (prog_ack === 1'b1) break;
        end
        prog_valid = 1'b0;
        check({31'h0, prog_ack}, 32'h1, "no step ack");
    endtask : prog_step

    initial begin
        // The frame lines belong to the host model alone
        {prog_valid, prog_instr, prog_type, prog_bank, prog_value} = '0;
        repeat (6) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        check(acc, 32'h0, "acc reset");
        check(pc, 32'h0, "pc reset");
        // Every math type from the host, bank byte junk, slow and fast hosts
        exp_acc = 32'h0;
        for (int op = 0; op < 10; op++) begin
            exp_acc = accumulator_math_cmd_ref(exp_acc, op[7:0], opv[op]);
            host_cmd(INS_MATH, op[7:0], op[7:0] + 8'h30, opv[op], STATUS_OK, opv[op], op % 3);
            check(acc, exp_acc, "math result");
        end
        // Division by zero is refused with status 3 and leaves the accumulator alone
        host_cmd(INS_MATH, OP_DIV, 8'h00, 32'h0, 8'h03, 32'h0, 0);
        check(acc, exp_acc, "div by zero moved acc");
        // A corrupted checksum must leave no trace but the error pulse
        host_u.send_frame(INS_MATH, OP_LOAD, 8'h00, 32'h1, 0, 1'b1);
        seen = 1'b0;
        repeat (3) begin
            seen |= (frame_err === 1'b1);
            @(posedge clk_sys_i);
            #1;
        end
        check({31'h0, seen}, 32'h1, "no frame error");
        repeat (14) @(posedge clk_sys_i);
        #1;
        check(host_u.reply_q.size(), 32'd0, "reply to bad frame");
        check(acc, exp_acc, "acc after bad frame");
        // Output lines set in a 1010 pattern, then read back without touching the accumulator
        for (int i = 0; i < 4; i++) host_cmd(INS_SET_OUTPUT, i[7:0], BANK_OUT_STATE, i % 2, STATUS_OK, 0, 0);
        check({28'h0, gpio_out}, 32'hA, "output lines");
        for (int i = 0; i < 4; i++) begin
            host_cmd(INS_GET_INPUT, i[7:0], BANK_OUT_STATE, 32'h0, STATUS_OK, i % 2, 0);
            check(acc, exp_acc, "direct read moved acc");
        end
        // Stored program: compare and jump are used only from here
        standalone = 1'b1;
        exp_pc = 32'h0;
        prog_step(INS_GET_INPUT, 8'h03, 32'h0);
        exp_pc++;
        check(acc, 32'h1, "standalone read to acc");
        for (int k = 0; k < 3; k++) begin
            prog_step(INS_MATH, OP_LOAD, acc_tab[k]);
            prog_step(INS_COMPARE, 8'h33, cmp_tab[k]);
            exp_pc += 2;
            for (int t = 0; t < 8; t++) begin
                prog_step(INS_COND_JUMP, t[7:0], 32'h100 + t);
                exp_pc = cond_ref(acc_tab[k], cmp_tab[k], t) ? 32'h100 + t : exp_pc + 1;
                check(pc, exp_pc, "compare jump");
            end
        end
        // Error flag jumps: timeout set by pulse and cleared by pulse, others live levels
        for (int t = 8; t < 12; t++) begin
            for (int s = 1; s >= 0; s--) begin
                @(posedge clk_sys_i);
                #1;
                if (t == 8) {wait_timeout, clear_err} = {s[0], 1'b1};
                else {position_err, deviation_err, ext_alarm} = s[0] ? (3'b001 << (t - 9)) : 3'b000;
                @(posedge clk_sys_i);
                #1;
                {wait_timeout, clear_err} = 2'b00;
                repeat (4) @(posedge clk_sys_i);
                #1;
                if (t == 8) check({31'h0, timeout_flag}, s, "timeout flag");
                prog_step(INS_COND_JUMP, t[7:0], 32'h200 + t);
                exp_pc = s[0] ? 32'h200 + t : exp_pc + 1;
                check(pc, exp_pc, "error jump");
            end
        end
        end_of_test();
    end
endmodule : accumulator_accumulator_math_cmd_compare_branch_tb_top
